// File: bench/nct_sequencer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module nct_sequencer_chk
   import nct_pkg::*;
(
   input wire logic                 clock,
   input wire logic                 rst,
   input wire logic                 cmd_valid,
   input wire nct_req_t             cmd_req,
   input wire logic                 cmd_ready,
   input wire logic                 busy,
   input wire logic                 done,
   input wire nct_cmd_t             done_cmd
);
   logic [3:0] cmd_q;
   logic       fw_q;
   int         cnt_q;

   function automatic int bus_of(logic [3:0] c, logic f);
      case (c)
         4'h0: return NCT_BUS_EV_ALL;
         4'h1: return NCT_BUS_EV_PBLK;
         4'h2: return NCT_BUS_EV_DBLK;
         4'h3: return NCT_BUS_EV_PSEC;
         4'h4: return NCT_BUS_EV_DSEC;
         4'h5: return NCT_BUS_VFY_KEY;
         4'h6: return NCT_BUS_MRG_USR;
         4'h7: return NCT_BUS_MRG_FAC;
         4'h8: return NCT_BUS_PGM_P4;
         4'h9: return NCT_BUS_ERS_ALL;
         4'ha: return NCT_BUS_ERS_PBLK;
         4'hb: return NCT_BUS_ERS_DBLK;
         4'hc: return NCT_BUS_ERS_PSEC;
         4'hd: return NCT_BUS_PGM_D1;
         4'he: return NCT_BUS_PGM_D2;
         default: return f ? NCT_BUS_PGM_D4 : NCT_BUS_PGM_D3;
      endcase
   endfunction : bus_of

   ////////////////////////////////////////////////////////////////////////////////
   // busy cycles since launch; restarts on a launch in the done cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_q <= 0;
      end else if (cmd_valid && cmd_ready) begin
         cnt_q <= 0;
      end else if (busy) begin
         cnt_q <= cnt_q + 1;
      end
   end

   always_ff @(posedge clock) begin
      if (cmd_valid && cmd_ready) begin
         cmd_q <= cmd_req.cmd;
         fw_q  <= cmd_req.four_words;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   property p_launch; cmd_valid && cmd_ready |=> busy && !cmd_ready; endproperty
   a_launch: assert property (p_launch) else $error("launch did not set busy");
   property p_refuse; busy |-> !cmd_ready; endproperty
   a_refuse: assert property (p_refuse) else $error("ready while busy");
   property p_min_busy; $rose(busy) |-> busy [*8]; endproperty
   a_min_busy: assert property (p_min_busy) else $error("busy dropped early");
   property p_pulse; done |=> !done; endproperty
   a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
   property p_fin; $fell(busy) |-> done; endproperty
   a_fin: assert property (p_fin) else $error("busy fell without done");
   property p_code; done |-> done_cmd == cmd_q; endproperty
   a_code: assert property (p_code) else $error("wrong completed code");
   property p_bus_only; done && cmd_q <= 4'h7 |-> cnt_q == bus_of(cmd_q, fw_q); endproperty
   a_bus_only: assert property (p_bus_only) else $error("bus-only time off");
   property p_floor; done |-> cnt_q >= bus_of(cmd_q, fw_q); endproperty
   a_floor: assert property (p_floor) else $error("bus count cut short");
endmodule : nct_sequencer_chk
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import nct_pkg::*;
   logic                 clock = 1'b0;
   logic                 rst = 1'b1;
   logic [NCT_DIV_W-1:0] div = NCT_DIV_RST;
   logic                 cmd_valid = 1'b0;
   nct_req_t             cmd_req = '0;
   logic [NCT_SEC_W-1:0] rd_sec = '0;
   wire logic            cmd_ready;
   wire logic            busy;
   wire logic            done;
   nct_cmd_t             done_cmd;
   logic [NCT_PEC_W-1:0] pe_cnt;
   int                   mismatches = 0;
   int                   n_checks = 0;
   int                   cyc = 0;

   always #12.5 clock = ~clock;

   nct_sequencer nct_sequencer_i (.clock(clock), .rst(rst), .nvm_clock_divider_reg(div),
      .cmd_valid(cmd_valid), .cmd_req(cmd_req), .cmd_ready(cmd_ready), .busy(busy),
      .done(done), .done_cmd(done_cmd), .pe_read_sector(rd_sec), .pe_read_count(pe_cnt));

   task automatic check(logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   // request held until taken, then count edges until done is seen
   task automatic run(nct_cmd_t c, logic fw, logic [5:0] s, output int n);
      cmd_valid <= 1'b1;
      cmd_req   <= '{c, fw, s};
      do @(posedge clock); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      n = 0;
      do begin n++; @(posedge clock); end while (done !== 1'b1);
      check(32'(done_cmd), 32'(c));
   endtask : run

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_refuse();
      int n;
      cmd_valid <= 1'b1;
      cmd_req   <= '{NCT_CMD_MRG_USR, 1'b0, 6'h00};
      do @(posedge clock); while (cmd_ready !== 1'b1);
      cmd_req.cmd <= NCT_CMD_VFY_KEY;
      repeat (5) @(posedge clock);
      check(32'(cmd_ready), 32'h0);
      cmd_valid <= 1'b0;
      n = 5;
      do begin n++; @(posedge clock); end while (done !== 1'b1);
      check(n, NCT_BUS_MRG_USR + 1);
      check(32'(done_cmd), 32'(NCT_CMD_MRG_USR));
   endtask : t_refuse

   task automatic t_bus();
      nct_cmd_t c[7] = '{NCT_CMD_EV_ALL, NCT_CMD_EV_PBLK, NCT_CMD_EV_DBLK, NCT_CMD_EV_PSEC,
                         NCT_CMD_EV_DSEC, NCT_CMD_VFY_KEY, NCT_CMD_MRG_FAC};
      int b[7] = '{NCT_BUS_EV_ALL, NCT_BUS_EV_PBLK, NCT_BUS_EV_DBLK, NCT_BUS_EV_PSEC,
                   NCT_BUS_EV_DSEC, NCT_BUS_VFY_KEY, NCT_BUS_MRG_FAC};
      int n;
      for (int i = 0; i < 7; i++) begin
         run(c[i], 1'b0, 6'h00, n);
         check(n, b[i] + 1);
      end
   endtask : t_bus

   // op-bound at divide 40, then divide 0 far outside the legal rate
   task automatic t_div();
      int n;
      div <= 8'h28;
      run(NCT_CMD_PGM_D1, 1'b0, 6'h00, n);
      check(32'(n >= 67 * 40 + 1 && n <= 68 * 40 + 42), 32'h1);
      div <= 8'h00;
      run(NCT_CMD_PGM_P4, 1'b0, 6'h00, n);
      check(n, NCT_BUS_PGM_P4 + 1);
      // four eeprom words ride on the three-word code with the flag set
      run(NCT_CMD_PGM_D3, 1'b1, 6'h00, n);
      check(n, NCT_BUS_PGM_D4 + 1);
   endtask : t_div

   task automatic t_erase();
      int n;
      div    <= 8'h01;
      rd_sec <= 6'h05;
      run(NCT_CMD_ERS_PSEC, 1'b0, 6'h05, n);
      check(32'(n >= 20015 && n <= 20018), 32'h1);
      repeat (2) @(posedge clock);
      check(32'(pe_cnt), 32'h1);
      rd_sec <= 6'h04;
      repeat (2) @(posedge clock);
      check(32'(pe_cnt), 32'h0);
   endtask : t_erase

   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test

   // ceiling sits just above the sum of all command times
   always @(posedge clock) begin
      cyc++;
      if (cyc == 110000) begin
         mismatches++;
         finish_test();
      end
   end

   initial begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      t_refuse();
      t_bus();
      t_div();
      t_erase();
      finish_test();
   end
endmodule : tb_top

bind nct_sequencer nct_sequencer_chk nct_sequencer_chk_i (.clock(clock), .rst(rst),
   .cmd_valid(cmd_valid), .cmd_req(cmd_req), .cmd_ready(cmd_ready), .busy(busy),
   .done(done), .done_cmd(done_cmd));
`default_nettype wire

// File: hdl/nct_op_clock.sv
`timescale 1ns/1ps
`default_nettype none
module nct_op_clock
   import nct_pkg::*;
(
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire logic [NCT_DIV_W-1:0] divider,
   output logic                      op_tick
);
   logic [NCT_DIV_W-1:0] cnt_q;

   // one tick every divider bus cycles; 0 treated as 1, the rate is never checked
   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_q   <= '0;
         op_tick <= 1'b0;
      end else if (cnt_q + 8'h01 >= divider) begin
         cnt_q   <= '0;
         op_tick <= 1'b1;
      end else begin
         cnt_q   <= cnt_q + 8'h01;
         op_tick <= 1'b0;
      end
   end
endmodule : nct_op_clock
`default_nettype wire

// File: hdl/nct_pe_counter.sv
`timescale 1ns/1ps
`default_nettype none
module nct_pe_counter
   import nct_pkg::*;
#(
   parameter int unsigned SECTORS = 64
) (
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire logic                 erase_sector,
   input  wire logic                 erase_all,
   input  wire logic [NCT_SEC_W-1:0] sector,
   input  wire logic [NCT_SEC_W-1:0] read_sector,
   output logic      [NCT_PEC_W-1:0] read_count
);
   logic [NCT_PEC_W-1:0] count_q [SECTORS];

   // a mass erase counts as one cycle on every sector
   generate
      for (genvar s = 0; s < SECTORS; s++) begin : g_sec
         always_ff @(posedge clock) begin
            if (rst) begin
               count_q[s] <= '0;
            end else if (erase_all ||
                         (erase_sector && sector == NCT_SEC_W'(s))) begin
               count_q[s] <= count_q[s] + 20'h00001;
            end
         end
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (rst) begin
         read_count <= '0;
      end else begin
         read_count <= count_q[read_sector];
      end
   end
endmodule : nct_pe_counter
`default_nettype wire

// File: hdl/nct_pkg.sv
package nct_pkg;

   localparam int unsigned NCT_DIV_W = 8;
   localparam int unsigned NCT_OPC_W = 17;
   localparam int unsigned NCT_BUS_W = 16;
   localparam int unsigned NCT_SEC_W = 6;
   localparam int unsigned NCT_PEC_W = 20;
   localparam logic [NCT_DIV_W-1:0] NCT_DIV_RST = 8'h28;

   typedef enum logic [3:0] {
      NCT_CMD_EV_ALL   = 4'h0,
      NCT_CMD_EV_PBLK  = 4'h1,
      NCT_CMD_EV_DBLK  = 4'h2,
      NCT_CMD_EV_PSEC  = 4'h3,
      NCT_CMD_EV_DSEC  = 4'h4,
      NCT_CMD_VFY_KEY  = 4'h5,
      NCT_CMD_MRG_USR  = 4'h6,
      NCT_CMD_MRG_FAC  = 4'h7,
      NCT_CMD_PGM_P4   = 4'h8,
      NCT_CMD_ERS_ALL  = 4'h9,
      NCT_CMD_ERS_PBLK = 4'ha,
      NCT_CMD_ERS_DBLK = 4'hb,
      NCT_CMD_ERS_PSEC = 4'hc,
      NCT_CMD_PGM_D1   = 4'hd,
      NCT_CMD_PGM_D2   = 4'he,
      NCT_CMD_PGM_D3   = 4'hf
   } nct_cmd_t;

   typedef struct packed {
      nct_cmd_t             cmd;
      logic                 four_words;
      logic [NCT_SEC_W-1:0] sector;
   } nct_req_t;

   typedef struct packed {
      logic [NCT_OPC_W-1:0] op_cycles;
      logic [NCT_BUS_W-1:0] bus_cycles;
   } nct_cost_t;

   localparam logic [NCT_BUS_W-1:0] NCT_BUS_EV_ALL   = 16'h8a38;
   localparam logic [NCT_BUS_W-1:0] NCT_BUS_EV_PBLK  = 16'h8239;
   localparam logic [NCT_BUS_W-1:0] NCT_BUS_EV_DBLK  = 16'h0a0d;
   localparam logic [NCT_BUS_W-1:0] NCT_BUS_EV_PSEC  = 16'h01f9;
   localparam logic [NCT_BUS_W-1:0] NCT_BUS_EV_DSEC  = 16'h0247;
   localparam logic [NCT_BUS_W-1:0] NCT_BUS_VFY_KEY  = 16'h0203;
   localparam logic [NCT_BUS_W-1:0] NCT_BUS_MRG_USR  = 16'h01ab;
   localparam logic [NCT_BUS_W-1:0] NCT_BUS_MRG_FAC  = 16'h01b4;
   localparam logic [NCT_BUS_W-1:0] NCT_BUS_PGM_P4   = 16'h0c05;
   localparam logic [NCT_BUS_W-1:0] NCT_BUS_ERS_ALL  = 16'h8bbd;
   localparam logic [NCT_BUS_W-1:0] NCT_BUS_ERS_PBLK = 16'h833c;
   localparam logic [NCT_BUS_W-1:0] NCT_BUS_ERS_DBLK = 16'h0b4f;
   localparam logic [NCT_BUS_W-1:0] NCT_BUS_ERS_PSEC = 16'h0392;
   localparam logic [NCT_BUS_W-1:0] NCT_BUS_PGM_D1   = 16'h0679;
   localparam logic [NCT_BUS_W-1:0] NCT_BUS_PGM_D2   = 16'h0a64;
   localparam logic [NCT_BUS_W-1:0] NCT_BUS_PGM_D3   = 16'h0e4f;
   localparam logic [NCT_BUS_W-1:0] NCT_BUS_PGM_D4   = 16'h123a;

   localparam logic [NCT_OPC_W-1:0] NCT_OPC_NONE     = 17'h00000;
   localparam logic [NCT_OPC_W-1:0] NCT_OPC_PGM_P4   = 17'h000a4;
   localparam logic [NCT_OPC_W-1:0] NCT_OPC_ERS_ALL  = 17'h186e2;
   localparam logic [NCT_OPC_W-1:0] NCT_OPC_ERS_BLK  = 17'h186dc;
   localparam logic [NCT_OPC_W-1:0] NCT_OPC_ERS_PSEC = 17'h04e2f;
   localparam logic [NCT_OPC_W-1:0] NCT_OPC_PGM_D1   = 17'h00044;
   localparam logic [NCT_OPC_W-1:0] NCT_OPC_PGM_D2   = 17'h00088;
   localparam logic [NCT_OPC_W-1:0] NCT_OPC_PGM_D3   = 17'h000cc;
   localparam logic [NCT_OPC_W-1:0] NCT_OPC_PGM_D4   = 17'h00110;

endpackage : nct_pkg

// File: hdl/nct_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module nct_sequencer
   import nct_pkg::*;
#(
   parameter int unsigned SECTORS = 64
) (
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire logic [NCT_DIV_W-1:0] nvm_clock_divider_reg,
   input  wire logic                 cmd_valid,
   input  wire nct_req_t             cmd_req,
   output logic                      cmd_ready,
   output logic                      busy,
   output logic                      done,
   output nct_cmd_t                  done_cmd,
   input  wire logic [NCT_SEC_W-1:0] pe_read_sector,
   output logic      [NCT_PEC_W-1:0] pe_read_count
);

   ////////////////////////////////////////////////////////////////////////////
   // cost lookup

   function automatic nct_cost_t cost_of(input nct_req_t r);
      nct_cost_t c;
      c.op_cycles  = NCT_OPC_NONE;
      c.bus_cycles = '0;
      unique case (r.cmd)
         NCT_CMD_EV_ALL:   c.bus_cycles = NCT_BUS_EV_ALL;
         NCT_CMD_EV_PBLK:  c.bus_cycles = NCT_BUS_EV_PBLK;
         NCT_CMD_EV_DBLK:  c.bus_cycles = NCT_BUS_EV_DBLK;
         NCT_CMD_EV_PSEC:  c.bus_cycles = NCT_BUS_EV_PSEC;
         NCT_CMD_EV_DSEC:  c.bus_cycles = NCT_BUS_EV_DSEC;
         NCT_CMD_VFY_KEY:  c.bus_cycles = NCT_BUS_VFY_KEY;
         NCT_CMD_MRG_USR:  c.bus_cycles = NCT_BUS_MRG_USR;
         NCT_CMD_MRG_FAC:  c.bus_cycles = NCT_BUS_MRG_FAC;
         NCT_CMD_PGM_P4: begin
            c.op_cycles  = NCT_OPC_PGM_P4;
            c.bus_cycles = NCT_BUS_PGM_P4;
         end
         NCT_CMD_ERS_ALL: begin
            c.op_cycles  = NCT_OPC_ERS_ALL;
            c.bus_cycles = NCT_BUS_ERS_ALL;
         end
         NCT_CMD_ERS_PBLK: begin
            c.op_cycles  = NCT_OPC_ERS_BLK;
            c.bus_cycles = NCT_BUS_ERS_PBLK;
         end
         NCT_CMD_ERS_DBLK: begin
            c.op_cycles  = NCT_OPC_ERS_BLK;
            c.bus_cycles = NCT_BUS_ERS_DBLK;
         end
         NCT_CMD_ERS_PSEC: begin
            c.op_cycles  = NCT_OPC_ERS_PSEC;
            c.bus_cycles = NCT_BUS_ERS_PSEC;
         end
         NCT_CMD_PGM_D1: begin
            c.op_cycles  = NCT_OPC_PGM_D1;
            c.bus_cycles = NCT_BUS_PGM_D1;
         end
         NCT_CMD_PGM_D2: begin
            c.op_cycles  = NCT_OPC_PGM_D2;
            c.bus_cycles = NCT_BUS_PGM_D2;
         end
         NCT_CMD_PGM_D3: begin
            // four eeprom words share this code with the four-word flag
            if (r.four_words) begin
               c.op_cycles  = NCT_OPC_PGM_D4;
               c.bus_cycles = NCT_BUS_PGM_D4;
            end else begin
               c.op_cycles  = NCT_OPC_PGM_D3;
               c.bus_cycles = NCT_BUS_PGM_D3;
            end
         end
      endcase
      return c;
   endfunction : cost_of

   ////////////////////////////////////////////////////////////////////////////
   // operation time base

   logic op_tick;

   nct_op_clock u_op_clock (
      .clock   (clock),
      .rst     (rst),
      .divider (nvm_clock_divider_reg),
      .op_tick (op_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // command state

   typedef enum logic [0:0] {
      NCT_IDLE = 1'b0,
      NCT_RUN  = 1'b1
   } nct_state_t;

   nct_state_t           state_q;
   nct_req_t             req_q;
   logic [NCT_OPC_W-1:0] op_left_q;
   logic [NCT_BUS_W-1:0] bus_left_q;
   logic                 launch;
   logic                 finish;
   nct_cost_t            cost;

   assign cost      = cost_of(cmd_req);
   assign cmd_ready = (state_q == NCT_IDLE);
   assign launch    = cmd_valid && cmd_ready;
   // both counts must reach zero; the bus count ends on its last cycle
   assign finish    = (state_q == NCT_RUN) && (op_left_q == '0) &&
                      (bus_left_q <= 16'h0001);

   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= NCT_IDLE;
      end else begin
         unique case (state_q)
            NCT_IDLE: if (launch) state_q <= NCT_RUN;
            NCT_RUN:  if (finish) state_q <= NCT_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         req_q <= '0;
      end else if (launch) begin
         req_q <= cmd_req;
      end
   end

   // the two counts run side by side; sequential operation would be longer
   // than the printed figures at a 1 MHz operation clock
   always_ff @(posedge clock) begin
      if (rst) begin
         op_left_q <= '0;
      end else if (launch) begin
         op_left_q <= cost.op_cycles;
      end else if (op_tick && op_left_q != '0) begin
         op_left_q <= op_left_q - 17'h00001;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         bus_left_q <= '0;
      end else if (launch) begin
         bus_left_q <= cost.bus_cycles;
      end else if (bus_left_q != '0) begin
         bus_left_q <= bus_left_q - 16'h0001;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         busy     <= 1'b0;
         done     <= 1'b0;
         done_cmd <= NCT_CMD_EV_ALL;
      end else begin
         busy <= launch || (busy && !finish);
         done <= finish;
         if (finish) done_cmd <= req_q.cmd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // program/erase cycle counts

   logic ers_sec;
   logic ers_all;

   assign ers_sec = finish && req_q.cmd == NCT_CMD_ERS_PSEC;
   assign ers_all = finish && (req_q.cmd == NCT_CMD_ERS_ALL ||
                               req_q.cmd == NCT_CMD_ERS_PBLK);

   nct_pe_counter #(
      .SECTORS (SECTORS)
   ) u_pe_counter (
      .clock        (clock),
      .rst          (rst),
      .erase_sector (ers_sec),
      .erase_all    (ers_all),
      .sector       (req_q.sector),
      .read_sector  (pe_read_sector),
      .read_count   (pe_read_count)
   );

endmodule : nct_sequencer
`default_nettype wire
